/* File: design/hce_core.sv */
`timescale 1ns/1ps

// bit fifo between code word loader and pulse-width sender
module hce_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // occupancy flags from pointers with wrap bit
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // storage
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid_i && !full) wr_ptr <= wr_ptr + 1'b1;
      if (out_ready_i && !empty) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// Summary of operation
// - wake on switch, wait 10 ms debounce
// - 32-bit block cipher, 64-bit key
// - cipher input: counter, fixed fields, buttons
// - new button aborts word, restarts processing
// - partial release ignored; last release finishes word
// - store: twelve 16-bit parameter words
// - key from words zero to three
// - counter updated every transmission
// - only low 28 identifier bits sent
// - identifier bit 31 enables auto-shutoff
// - 25 s hold enters time-out, stops
// - outer wrap enciphers identifier and function
// - option word field layout
// - programming: third switch clock, output data
// - indicator sinks current while transmitting
// - function from level presses and buttons
// - rate bits pick element and blanking
module hce_core #(
  parameter longint unsigned DEBOUNCE_CYC = hce_pkg::DEBOUNCE_MS * hce_pkg::CLK_HZ / 1000,
  parameter longint unsigned SHUTOFF_CYC = hce_pkg::SHUTOFF_S * hce_pkg::CLK_HZ,
  parameter longint unsigned TE_BASE_CYC = hce_pkg::TE_BASE_US * hce_pkg::CLK_HZ / 1000000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // switch inputs
  input wire logic button_input_a_i,
  input wire logic button_input_b_i,
  input wire logic button_input_c_prog_clock_i,
  input wire logic level_select_i,
  // status inputs
  input wire logic prog_mode_i,
  input wire logic low_voltage_i,
  // output pin, also programming data
  input wire logic pwm_data_i,
  output logic pwm_o,
  output logic pwm_oe_o,
  // indicator, low sinks current
  output logic led_b_o,
  output hce_pkg::hce_state_t state_o
);
  import hce_pkg::*;

  localparam logic [31:0] DEB_LEN = 32'(DEBOUNCE_CYC);
  localparam logic [31:0] SHUT_LEN = 32'(SHUTOFF_CYC);
  localparam logic [31:0] TE_LEN = 32'(TE_BASE_CYC);

  hce_state_t state;
  hce_state_t next_state;
  logic [15:0] store [WORD_COUNT];
  hce_buttons_t btn;
  hce_buttons_t btn_latched;
  logic any_tx;
  logic new_press;
  logic [31:0] deb_cnt;
  logic [31:0] shut_cnt;
  logic [31:0] te_cnt;
  logic [31:0] te_len;
  logic te_tick;
  logic [1:0] shift_level;
  logic level_prev;
  logic [3:0] func;
  logic [9:0] round;
  logic [31:0] hop_block;
  logic [63:0] key_rot;
  logic [31:0] env_block;
  logic [15:0] env_key;
  hce_code_word_t code_word;
  logic [6:0] load_left;
  logic [65:0] load_sr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_pop;
  logic fifo_flush;
  logic [6:0] bits_sent;
  logic [5:0] elem_cnt;
  logic [1:0] sub;
  logic cur_bit;
  logic [1:0] word_idx;
  logic send_en;
  logic [1:0] rate;
  logic prog_clk_prev;
  logic [3:0] prog_bits;
  logic [15:0] prog_sr;
  logic [3:0] prog_addr;
  logic tx_active;
  logic shut_en;
  logic next_pwm;

  assign btn = '{c: button_input_c_prog_clock_i, b: button_input_b_i, a: button_input_a_i};
  assign any_tx = |btn;
  assign new_press = |(btn & ~btn_latched);
  assign rate = {store[ADDR_OPTION_WORD][OPT_RATE_SELECT_HIGH],
                 store[ADDR_OPTION_WORD][OPT_RATE_SELECT_LOW]};
  assign shut_en = store[ADDR_UNIT_ID_HIGH][UNIT_ID_SHUTOFF_BIT];
  assign tx_active = (state == HCE_PREAMBLE) || (state == HCE_HEADER) ||
                     (state == HCE_DATA) || (state == HCE_GUARD);
  assign fifo_flush = (state == HCE_SAMPLE);

  // element length and blanking from the rate bits
  always_comb begin
    unique case (rate)
      2'b00: te_len = TE_LEN << 2;
      2'b01: te_len = TE_LEN << 1;
      default: te_len = TE_LEN;
    endcase
    unique case (rate)
      2'b00: send_en = 1'b1;
      2'b11: send_en = (word_idx == 2'b00);
      default: send_en = !word_idx[0];
    endcase
  end

  // function code: level presses high, button encoding low
  always_comb begin
    func = {shift_level, (btn.c ? 2'b11 : {btn.b, btn.a})};
  end

  // main sequence
  always_comb begin
    next_state = state;
    unique case (state)
      HCE_IDLE: if ((any_tx || level_select_i) && !prog_mode_i) next_state = HCE_DEBOUNCE;
      HCE_DEBOUNCE: if (deb_cnt >= DEB_LEN - 1) begin
        if (any_tx) next_state = HCE_SAMPLE;
        else if (!level_select_i) next_state = HCE_IDLE;
      end
      HCE_SAMPLE: next_state = HCE_CIPHER;
      HCE_CIPHER: if (round == 10'(CIPHER_ROUNDS - 1)) next_state = HCE_PREAMBLE;
      HCE_PREAMBLE: if (te_tick && elem_cnt == 6'(PREAMBLE_TE - 1)) next_state = HCE_HEADER;
      HCE_HEADER: if (te_tick && elem_cnt == 6'(HEADER_TE - 1)) next_state = HCE_DATA;
      HCE_DATA: if (te_tick && sub == 2'(TE_PER_BIT - 1) && bits_sent == 7'(WORD_BITS - 1))
        next_state = HCE_GUARD;
      HCE_GUARD: if (te_tick && elem_cnt == 6'(GUARD_TE - 1))
        next_state = any_tx ? HCE_SAMPLE : HCE_IDLE;
      HCE_TIMEOUT: if (!any_tx) next_state = HCE_IDLE;
      default: next_state = HCE_IDLE;
    endcase
    if (tx_active && new_press) next_state = HCE_DEBOUNCE;
    if (shut_en && shut_cnt >= SHUT_LEN - 1 && state != HCE_IDLE) next_state = HCE_TIMEOUT;
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) state <= HCE_IDLE;
    else state <= next_state;
  end

  // debounce delay, restarted on every entry
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) deb_cnt <= '0;
    else if (state != HCE_DEBOUNCE || next_state != HCE_DEBOUNCE) deb_cnt <= '0;
    else deb_cnt <= deb_cnt + 32'h1;
  end

  // stuck button timer, runs while any transmit button is held
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) shut_cnt <= '0;
    else if (!any_tx || !shut_en || state == HCE_IDLE) shut_cnt <= '0;
    else if (shut_cnt < SHUT_LEN - 1) shut_cnt <= shut_cnt + 32'h1;
  end

  // level-select press counter, cleared once the word goes out
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_level <= '0;
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_select_i;
      if ((tx_active || state == HCE_TIMEOUT) && next_state == HCE_IDLE) shift_level <= '0;
      else if (level_select_i && !level_prev && shift_level != MAX_SHIFT_LEVEL && !tx_active)
        shift_level <= shift_level + 2'h1;
    end
  end

  // pulse element divider
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      te_cnt <= '0;
      te_tick <= 1'b0;
    end else if (!tx_active) begin
      te_cnt <= '0;
      te_tick <= 1'b0;
    end else begin
      te_tick <= (te_cnt == te_len - 2);
      te_cnt <= (te_cnt >= te_len - 1) ? '0 : te_cnt + 32'h1;
    end
  end

  // parameter store: sampling updates counter, programming loads words
  always_ff @(posedge clk_i) begin
    if (state == HCE_SAMPLE) begin
      store[ADDR_HOP_COUNTER] <= store[ADDR_HOP_COUNTER] + 16'h1;
      if (store[ADDR_HOP_COUNTER] == HOP_ALL_ONES) begin
        if (store[ADDR_OPTION_WORD][OPT_WRAP_FLAG_FIRST])
          store[ADDR_OPTION_WORD][OPT_WRAP_FLAG_FIRST] <= 1'b0;
        else
          store[ADDR_OPTION_WORD][OPT_WRAP_FLAG_SECOND] <= 1'b0;
      end
    end else if (prog_mode_i && state == HCE_IDLE && prog_bits == 4'hf &&
                 button_input_c_prog_clock_i && !prog_clk_prev) begin
      store[prog_addr] <= (prog_addr == ADDR_RESERVED) ? RESERVED_VALUE :
                          {pwm_data_i, prog_sr[15:1]};
    end
  end

  // serial programming shifter, clocked by the third switch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_clk_prev <= 1'b0;
      prog_bits <= '0;
      prog_sr <= '0;
      prog_addr <= ADDR_KEY_FIRST;
    end else begin
      prog_clk_prev <= button_input_c_prog_clock_i;
      if (!prog_mode_i) begin
        prog_bits <= '0;
        prog_addr <= ADDR_KEY_FIRST;
      end else if (state == HCE_IDLE && button_input_c_prog_clock_i && !prog_clk_prev) begin
        prog_sr <= {pwm_data_i, prog_sr[15:1]};
        prog_bits <= prog_bits + 4'h1;
        if (prog_bits == 4'hf) prog_addr <= (prog_addr == ADDR_LAST) ? ADDR_KEY_FIRST :
                                             prog_addr + 4'h1;
      end
    end
  end

  // block cipher rounds; plaintext mixes counter, fixed fields, buttons
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      round <= '0;
      hop_block <= '0;
      key_rot <= '0;
      btn_latched <= '0;
    end else if (state == HCE_SAMPLE) begin
      round <= '0;
      btn_latched <= btn;
      hop_block <= {func, store[ADDR_OPTION_WORD][OPT_WRAP_FLAG_SECOND:OPT_WRAP_FLAG_FIRST],
                    store[ADDR_OPTION_WORD][OPT_DISC_MSB:OPT_DISC_LSB],
                    store[ADDR_HOP_COUNTER] + 16'h1};
      key_rot <= {store[ADDR_KEY_FIRST + 4'h3], store[ADDR_KEY_FIRST + 4'h2],
                  store[ADDR_KEY_FIRST + 4'h1], store[ADDR_KEY_FIRST]};
    end else if (state == HCE_CIPHER) begin
      round <= round + 10'h1;
      hop_block <= {NLF_TABLE[{hop_block[31], hop_block[26], hop_block[20], hop_block[9],
                    hop_block[1]}] ^ hop_block[16] ^ hop_block[0] ^ key_rot[0],
                    hop_block[31:1]};
      key_rot <= {key_rot[0], key_rot[63:1]};
    end else if (tx_active) begin
      btn_latched <= btn_latched & btn;
    end
  end

  // outer wrap of identifier and function, a separate short mixer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      env_block <= '0;
      env_key <= '0;
    end else if (state == HCE_SAMPLE) begin
      env_block <= {func, store[ADDR_UNIT_ID_HIGH][UNIT_ID_TX_BITS-17:0],
                    store[ADDR_UNIT_ID_LOW]};
      env_key <= store[ADDR_OUTER_WRAP_SECRET];
    end else if (state == HCE_CIPHER && round < 10'(ENV_ROUNDS) &&
                 store[ADDR_OPTION_WORD][OPT_OUTER_WRAP_ENABLE]) begin
      env_block <= {env_block[30:0], env_block[31] ^ env_key[0] ^
                    (env_block[7] & env_block[19])};
      env_key <= {env_key[0], env_key[15:1]};
    end
  end

  assign code_word = '{status: {low_voltage_i, (state == HCE_GUARD)},
                       fixed: env_block, hop: hop_block};

  // loader: shifts the code word into the fifo, stalls on back-pressure
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_left <= '0;
      load_sr <= '0;
    end else if (state == HCE_SAMPLE) begin
      load_left <= '0;
    end else if (state == HCE_CIPHER && next_state == HCE_PREAMBLE) begin
      load_left <= 7'(WORD_BITS);
      load_sr <= {code_word.status, code_word.fixed, hop_block};
    end else if (load_left != 7'h0 && fifo_in_ready) begin
      load_left <= load_left - 7'h1;
      load_sr <= {1'b0, load_sr[65:1]};
    end
  end

  hce_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(fifo_flush),
    .in_valid_i(load_left != 7'h0),
    .in_ready_o(fifo_in_ready),
    .in_data_i(load_sr[0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  assign fifo_pop = (state == HCE_DATA) && te_tick && sub == 2'(TE_PER_BIT - 1);

  // element and bit counters of the word
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      elem_cnt <= '0;
      sub <= '0;
      bits_sent <= '0;
      word_idx <= '0;
    end else if (state != next_state) begin
      elem_cnt <= '0;
      sub <= '0;
      bits_sent <= '0;
      if (state == HCE_GUARD && next_state == HCE_SAMPLE) word_idx <= word_idx + 2'h1;
      if (next_state == HCE_IDLE) word_idx <= '0;
    end else if (te_tick) begin
      elem_cnt <= elem_cnt + 6'h1;
      if (state == HCE_DATA) begin
        sub <= (sub == 2'(TE_PER_BIT - 1)) ? 2'h0 : sub + 2'h1;
        if (sub == 2'(TE_PER_BIT - 1)) bits_sent <= bits_sent + 7'h1;
      end
    end
  end

  assign cur_bit = fifo_out_valid & fifo_out_data;

  // pulse shape: high element, inverted data element, low element
  always_comb begin
    unique case (state)
      HCE_PREAMBLE: next_pwm = !elem_cnt[0];
      HCE_DATA: next_pwm = (sub == 2'h0) || (sub == 2'h1 && !cur_bit);
      default: next_pwm = 1'b0;
    endcase
  end

  // registered pins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_o <= 1'b0;
      pwm_oe_o <= 1'b0;
      led_b_o <= 1'b1;
      state_o <= HCE_IDLE;
    end else begin
      pwm_o <= next_pwm && send_en;
      pwm_oe_o <= !prog_mode_i;
      led_b_o <= !(tx_active && next_state != HCE_TIMEOUT);
      state_o <= next_state;
    end
  end

  a_debounce_len: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state == HCE_DEBOUNCE && next_state == HCE_SAMPLE) |-> deb_cnt >= DEB_LEN - 1)
    else $error("debounce left early");
  a_counter_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state == HCE_SAMPLE |=> store[ADDR_HOP_COUNTER] == $past(store[ADDR_HOP_COUNTER]) + 16'h1)
    else $error("counter not advanced");
  a_plain_counter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state == HCE_SAMPLE |=> round == 10'h0 && hop_block[15:0] == store[ADDR_HOP_COUNTER])
    else $error("cipher input lacks new counter");
  a_abort_press: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tx_active && new_press && !(shut_en && shut_cnt >= SHUT_LEN - 1)) |=> state == HCE_DEBOUNCE)
    else $error("new button did not abort");
  a_release_done: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state == HCE_DATA && !any_tx && !(shut_en && shut_cnt >= SHUT_LEN - 1)) |=>
    state inside {HCE_DATA, HCE_GUARD})
    else $error("release cut the word");
  a_key_order: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state == HCE_SAMPLE |=> key_rot[15:0] == store[ADDR_KEY_FIRST])
    else $error("key not taken from word zero");
  a_led_tx: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state == HCE_HEADER && next_state == HCE_HEADER) |=> !led_b_o)
    else $error("indicator dark during word");
  a_timeout_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state == HCE_TIMEOUT |=> !pwm_o && led_b_o)
    else $error("output active in time-out");
  a_prog_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    prog_mode_i |=> !pwm_oe_o)
    else $error("output driven while programming");
  a_blank_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rate == 2'b11 && word_idx != 2'b00 && $stable(rate)) |=> !pwm_o)
    else $error("blanked word was sent");
endmodule

/* File: design/hce_pkg.sv */
package hce_pkg;
  // clock and timing
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned DEBOUNCE_MS = 10;
  localparam longint unsigned SHUTOFF_S = 25;
  localparam longint unsigned TE_BASE_US = 100;
  localparam int unsigned PREAMBLE_TE = 23;
  localparam int unsigned HEADER_TE = 10;
  localparam int unsigned GUARD_TE = 30;
  localparam int unsigned TE_PER_BIT = 3;
  // parameter store map (word addresses)
  localparam int WORD_COUNT = 12;
  localparam logic [3:0] ADDR_KEY_FIRST = 4'h0;
  localparam logic [3:0] ADDR_HOP_COUNTER = 4'h4;
  localparam logic [3:0] ADDR_RESERVED = 4'h5;
  localparam logic [3:0] ADDR_UNIT_ID_LOW = 4'h6;
  localparam logic [3:0] ADDR_UNIT_ID_HIGH = 4'h7;
  localparam logic [3:0] ADDR_OUTER_WRAP_SECRET = 4'ha;
  localparam logic [3:0] ADDR_OPTION_WORD = 4'hb;
  localparam logic [3:0] ADDR_LAST = 4'hb;
  localparam logic [15:0] RESERVED_VALUE = 16'h0000;
  // option word and identifier fields
  localparam int OPT_DISC_LSB = 0;
  localparam int OPT_DISC_MSB = 9;
  localparam int OPT_WRAP_FLAG_FIRST = 10;
  localparam int OPT_WRAP_FLAG_SECOND = 11;
  localparam int OPT_LOW_VOLT_SEL = 12;
  localparam int OPT_RATE_SELECT_LOW = 13;
  localparam int OPT_RATE_SELECT_HIGH = 14;
  localparam int OPT_OUTER_WRAP_ENABLE = 15;
  localparam int UNIT_ID_SHUTOFF_BIT = 15;
  localparam int UNIT_ID_TX_BITS = 28;
  // cipher
  localparam int unsigned CIPHER_ROUNDS = 528;
  localparam int unsigned ENV_ROUNDS = 32;
  localparam logic [31:0] NLF_TABLE = 32'h3a5c_74e2;
  localparam int WORD_BITS = 66;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] HOP_ALL_ONES = 16'hffff;
  localparam logic [1:0] MAX_SHIFT_LEVEL = 2'h3;

  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } hce_buttons_t;

  typedef struct packed {
    logic [1:0] status;
    logic [31:0] fixed;
    logic [31:0] hop;
  } hce_code_word_t;

  typedef enum logic [3:0] {
    HCE_IDLE = 4'h0,
    HCE_DEBOUNCE = 4'h1,
    HCE_SAMPLE = 4'h3,
    HCE_CIPHER = 4'h2,
    HCE_PREAMBLE = 4'h6,
    HCE_HEADER = 4'h7,
    HCE_DATA = 4'h5,
    HCE_GUARD = 4'h4,
    HCE_TIMEOUT = 4'hc
  } hce_state_t;
endpackage

/* File: testbench/hce_core_tb.sv */
`timescale 1ns/1ps

// programs the store, presses buttons and decodes the pulse stream
module hce_core_tb;
  import hce_pkg::*;
  localparam longint unsigned DEB = 20;
  localparam longint unsigned SHUT = 3000;
  localparam longint unsigned TEB = 4;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic bt_a = 1'b0, bt_b = 1'b0, bt_c = 1'b0, lvl = 1'b0;
  logic prog = 1'b0, lowv = 1'b0, pdrv = 1'b0, hi;
  logic pwm_o, pwm_oe_o, led_b_o;
  hce_state_t state_o;
  logic [65:0] rx_word;
  logic [15:0] rx_te;
  int rx_n, n0, k;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h1c4064f5;
  logic [31:0] last_hop = 32'h0;
  logic [15:0] mem [12];
  logic [2:0] bts [4] = '{3'b001, 3'b010, 3'b011, 3'b100};

  // device with shortened counts; data pin level from both drivers
  hce_core #(.DEBOUNCE_CYC(DEB), .SHUTOFF_CYC(SHUT), .TE_BASE_CYC(TEB)) i_hce_core (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .button_input_a_i(bt_a), .button_input_b_i(bt_b),
    .button_input_c_prog_clock_i(bt_c), .level_select_i(lvl),
    .prog_mode_i(prog), .low_voltage_i(lowv),
    .pwm_data_i(pwm_oe_o ? pwm_o : pdrv), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
    .led_b_o(led_b_o), .state_o(state_o));

  hce_rx_model i_hce_rx_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .pwm_i(pwm_o),
    .word_o(rx_word), .te_o(rx_te), .n_words_o(rx_n));

  always #5 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_st(input hce_state_t s, input int lim);
    k = 0;
    while (state_o !== s && k < lim) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  // random store content, shifted in lsb first on the third switch
  task automatic setup(input logic [1:0] rt, input logic wrap, input logic shut);
    logic [31:0] r;
    foreach (mem[i]) begin
      r = rnd();
      mem[i] = r[15:0];
    end
    mem[7][15] = shut;
    mem[11][15:13] = {wrap, rt};
    lowv = r[20];
    prog = 1'b1;
    @(negedge clk_i);  // let the device release the data pin before the first shift
    for (int w = 0; w < 12; w++) begin
      for (int b = 0; b < 16; b++) begin
        pdrv = mem[w][b];
        bt_c = 1'b1;
        repeat (2) @(negedge clk_i);
        bt_c = 1'b0;
        repeat (2) @(negedge clk_i);
      end
    end
    chk(pwm_oe_o, 1'b0);
    prog = 1'b0;
    @(negedge clk_i);
  endtask

  // level presses, then a chord released early; one whole word expected
  task automatic send(input int lv, input logic [2:0] bt);
    logic [3:0] fn;
    logic [1:0] rt;
    fn = {lv[1:0], bt[2] ? 2'b11 : bt[1:0]};
    rt = mem[11][14:13];
    for (int i = 0; i < lv; i++) begin
      lvl = 1'b1;
      repeat (DEB + 10) @(negedge clk_i);
      lvl = 1'b0;
      wait_st(HCE_IDLE, 200);
      @(negedge clk_i);
    end
    n0 = rx_n;
    {bt_c, bt_b, bt_a} = bt;
    @(negedge clk_i);
    chk(state_o, HCE_DEBOUNCE);
    wait_st(HCE_SAMPLE, 200);
    chk(k >= DEB - 2 && k <= DEB + 2, 1'b1);
    wait_st(HCE_CIPHER, 10);
    {bt_c, bt_b, bt_a} = 3'b000;
    wait_st(HCE_DATA, 3000);
    chk(led_b_o, 1'b0);
    wait_st(HCE_IDLE, 20000);
    chk(rx_n, n0 + 1);
    chk(rx_word[63:32], {fn, mem[7][11:0], mem[6]});
    chk(rx_word[65:64], {lowv, 1'b0});
    chk(rx_te, 16'(TEB * (rt == 2'b00 ? 4 : rt == 2'b01 ? 2 : 1)));
    chk(rx_word[31:0] !== last_hop, 1'b1);
    last_hop = rx_word[31:0];
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk_i);
    chk({pwm_o, pwm_oe_o, led_b_o, state_o}, {3'b001, HCE_IDLE});
    rst_b_i = 1'b1;
    // every rate and level count once, random chords
    for (int r = 0; r < 4; r++) begin
      setup(r[1:0], 1'b0, 1'b0);
      send(r, bts[rnd() % 4]);
    end
    // same chord twice: the counter moves the hop field
    setup(2'b00, 1'b0, 1'b0);
    send(0, 3'b001);
    send(0, 3'b001);
    // extra button mid-word aborts; dropping one of two keeps the word
    n0 = rx_n;
    bt_a = 1'b1;
    wait_st(HCE_DATA, 3000);
    bt_b = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(state_o, HCE_DEBOUNCE);
    wait_st(HCE_DATA, 3000);
    bt_b = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(state_o, HCE_DATA);
    bt_a = 1'b0;
    wait_st(HCE_IDLE, 20000);
    chk({rx_n, rx_word[63:60]}, {n0 + 1, 4'b0011});
    // shutoff disabled, outer wrap on, one word in four: a stuck button keeps sending
    setup(2'b11, 1'b1, 1'b0);
    n0 = rx_n;
    bt_a = 1'b1;
    repeat (SHUT + 300) @(negedge clk_i);
    chk(state_o !== HCE_TIMEOUT, 1'b1);
    bt_a = 1'b0;
    wait_st(HCE_IDLE, 20000);
    chk(rx_n, n0 + 1);
    chk(rx_word[63:32] !== {4'b0001, mem[7][11:0], mem[6]}, 1'b1);
    // shutoff enabled: stuck button times out and goes quiet
    setup(2'b10, 1'b0, 1'b1);
    bt_a = 1'b1;
    wait_st(HCE_TIMEOUT, SHUT + 500);
    chk(k > SHUT - 20 && k < SHUT + 20, 1'b1);
    hi = 1'b0;
    repeat (200) begin
      @(negedge clk_i);
      hi = hi | pwm_o;
    end
    chk({hi, led_b_o}, 2'b01);
    bt_a = 1'b0;
    wait_st(HCE_IDLE, 200);
    chk(state_o, HCE_IDLE);
    final_report();
  end
endmodule

/* File: testbench/hce_rx_model.sv */
`timescale 1ns/1ps

// receiver stand-in: rebuilds words from pulse widths
module hce_rx_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // received stream
  input wire logic pwm_i,
  // decoded word, element length, word count
  output logic [65:0] word_o,
  output logic [15:0] te_o,
  output int n_words_o
);
  logic prev;
  logic [15:0] run;
  logic [15:0] hi_len;
  int nbit;
  // a long low after a short high marks a header; a short high is a one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev <= 1'b0;
      run <= 16'h0;
      hi_len <= 16'hffff;
      te_o <= 16'h0;
      word_o <= '0;
      nbit <= 66;
      n_words_o <= 0;
    end else begin
      prev <= pwm_i;
      run <= (pwm_i != prev) ? 16'h1 : run + {15'h0, run != 16'hffff};
      if (pwm_i && !prev && run > {hi_len[13:0], 2'b00}) begin
        te_o <= hi_len;
        nbit <= 0;
      end
      if (!pwm_i && prev) begin
        hi_len <= run;
        if (nbit < 66) begin
          word_o[nbit] <= (run * 16'h2 < te_o * 16'h3);
          nbit <= nbit + 1;
          n_words_o <= n_words_o + ((nbit == 65) ? 1 : 0);
        end
      end
    end
  end
endmodule
